/* pkg/ffr_params.svh */
// Constants, offsets and field positions for the fault flag registers
// Contract
// - Thermal flag bits 15/14 clear together
// - Resistor short flag bit 13, ack 12
// - String config resistor flag 11, ack 10
// - Mode resistor flag 9, ack 8
// - Frequency resistor flag 7, ack 6
// - Boost overcurrent flag 5, ack 4
// - Boost overvolt high flag 3, ack 2
// - Boost overvolt low flag bit 1
// - Overvolt low clear leaves pin alone; here clearing bit 1 drops irq_o when it is the only enabled flag
// - String register at 0x12, resets zero
// - Boost register at 0x10, resets zero
`ifndef FFR_PARAMS_SVH
`define FFR_PARAMS_SVH
`define FFR_ADDR_W 8
`define FFR_DATA_W 16
`define FFR_NUM_BOOST 8
`define FFR_NUM_STR 4
`define FFR_OFS_BOOST 8'h10
`define FFR_OFS_STRING 8'h12
`define FFR_OFS_STR_MASK 8'h20
`define FFR_OFS_BOOST_MASK 8'h22
`define FFR_OFS_LED_LIVE 8'h24
`define FFR_RESET_VAL 16'h0000
`define FFR_MASK_RESET 16'hFFFF
`define FFR_BIT_TSD 15
`define FFR_BIT_CURRENT_SET_RESISTOR 13
`define FFR_BIT_STRCFG 11
`define FFR_BIT_MODE 9
`define FFR_BIT_FREQ 7
`define FFR_BIT_BOCP 5
`define FFR_BIT_OVPH 3
`define FFR_BIT_OVPL 1
`define FFR_BIT_I2CERR 14
`define FFR_BIT_INVSTR 12
`define FFR_BIT_LEDF 10
`define FFR_BIT_GND 8
`define FFR_BIT_SHORT 7
`define FFR_BIT_OPEN 6
`define FFR_STR_RW_MASK 16'h7E00
`endif

/* pkg/ffr_pkg.sv */
// Types for the fault flag registers
package ffr_pkg;
   typedef logic [15:0] ffr_word_t;
endpackage

/* logic/ffr_sync.sv */
// Three-stage synchroniser with agreement on the last two stages
`timescale 1ns/1ps
`default_nettype none
module ffr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q_o <= '0;
      end else begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         q_o <= (s2 & s3) | (q_o & (s2 | s3));
      end
   end
endmodule // ffr_sync
`default_nettype wire

/* logic/ffr_top.sv */
// Fault flag register bank with interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ffr_params.svh"
module ffr_top (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Register port
   input wire logic [`FFR_ADDR_W-1:0] addr_i,
   input wire ffr_pkg::ffr_word_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`FFR_DATA_W-1:0] rdata_o,
   // Fault detector levels
   input wire logic [`FFR_NUM_BOOST-1:0] boost_fault_i,
   input wire logic i2c_timeout_fault_i,
   input wire logic invalid_string_fault_i,
   input wire logic led_gnd_fault_i,
   input wire logic led_short_fault_i,
   input wire logic led_open_fault_i,
   input wire logic [`FFR_NUM_STR-1:0] led_string_fault_i,
   // Interrupt
   output logic irq_o
);
   import ffr_pkg::*;

   typedef struct packed {
      logic [`FFR_NUM_BOOST-1:0] bflag;
      logic [`FFR_NUM_BOOST-1:0] back;
      logic [`FFR_NUM_BOOST-1:0] bprev;
      logic [2:0] sflag;
      logic [2:0] sack;
      logic [2:0] sprev;
      logic gnd;
      logic shrt;
      logic open;
      logic [`FFR_NUM_STR-1:0] leds;
      ffr_word_t bmask;
      ffr_word_t smask;
      ffr_word_t rdata;
      logic irq;
   } ffr_state_s;

   ffr_state_s st;
   ffr_state_s next_st;
   logic rst_a;
   logic rst_n;
   logic [`FFR_NUM_BOOST-1:0] bsync;
   logic [2:0] ssync;
   logic [2:0] ledsync;
   logic [`FFR_NUM_STR-1:0] strsync;
   ffr_word_t boost_word;
   ffr_word_t str_word;
   logic [`FFR_NUM_BOOST-1:0] brise;
   logic [2:0] srise;

   // Flag bit position of boost slot i
   function automatic int flag_pos(input int i);
      return `FFR_BIT_OVPL + 2 * i;
   endfunction

   // Register address match
   function automatic logic hit(input logic [`FFR_ADDR_W-1:0] a,
                                input logic [`FFR_ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   // Reset release
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_a <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_n <= rst_a;
      end
   end

   // Detector inputs
   ffr_sync #(.W(`FFR_NUM_BOOST)) u_sync_boost (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .d_i(boost_fault_i),
      .q_o(bsync)
   );
   ffr_sync #(.W(3)) u_sync_str (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .d_i({led_open_fault_i, invalid_string_fault_i, i2c_timeout_fault_i}),
      .q_o(ssync)
   );
   ffr_sync #(.W(3)) u_sync_led (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .d_i({led_open_fault_i, led_short_fault_i, led_gnd_fault_i}),
      .q_o(ledsync)
   );
   ffr_sync #(.W(`FFR_NUM_STR)) u_sync_leds (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .d_i(led_string_fault_i),
      .q_o(strsync)
   );

   assign brise = bsync & ~st.bprev;
   assign srise = {(ledsync[0] | ledsync[1] | ledsync[2]), ssync[1:0]} & ~st.sprev;

   // Register images
   always_comb begin
      boost_word = `FFR_RESET_VAL;
      for (int i = 0; i < `FFR_NUM_BOOST; i++) begin
         boost_word[flag_pos(i)] = st.bflag[i];
         boost_word[flag_pos(i) - 1] = st.back[i];
      end
      str_word = `FFR_RESET_VAL;
      str_word[`FFR_BIT_I2CERR] = st.sflag[0];
      str_word[`FFR_BIT_I2CERR - 1] = st.sack[0];
      str_word[`FFR_BIT_INVSTR] = st.sflag[1];
      str_word[`FFR_BIT_INVSTR - 1] = st.sack[1];
      str_word[`FFR_BIT_LEDF] = st.sflag[2];
      str_word[`FFR_BIT_LEDF - 1] = st.sack[2];
      str_word[`FFR_BIT_GND] = st.gnd;
      str_word[`FFR_BIT_SHORT] = st.shrt;
      str_word[`FFR_BIT_OPEN] = st.open;
      str_word[`FFR_NUM_STR-1:0] = st.leds;
   end

   // Next state
   always_comb begin
      logic wb;
      logic ws;
      logic [`FFR_NUM_BOOST-1:0] bclr;
      logic [2:0] sclr;
      wb = 1'b0;
      ws = 1'b0;
      bclr = '0;
      sclr = '0;
      next_st = st;
      wb = wr_i && hit(addr_i, `FFR_OFS_BOOST);
      ws = wr_i && hit(addr_i, `FFR_OFS_STRING);
      next_st.bprev = bsync;
      next_st.sprev = {(ledsync[0] | ledsync[1] | ledsync[2]), ssync[1:0]};
      for (int i = 0; i < `FFR_NUM_BOOST; i++) begin
         bclr[i] = wb && wdata_i[flag_pos(i)] && wdata_i[flag_pos(i) - 1];
         if (wb) begin
            next_st.back[i] = wdata_i[flag_pos(i) - 1] & ~bclr[i];
         end
         next_st.bflag[i] = brise[i] | (st.bflag[i] & ~bclr[i]);
      end
      sclr[0] = ws && wdata_i[`FFR_BIT_I2CERR] && wdata_i[`FFR_BIT_I2CERR - 1];
      sclr[1] = ws && wdata_i[`FFR_BIT_INVSTR] && wdata_i[`FFR_BIT_INVSTR - 1];
      sclr[2] = ws && wdata_i[`FFR_BIT_LEDF] && wdata_i[`FFR_BIT_LEDF - 1];
      if (ws) begin
         next_st.sack = {wdata_i[`FFR_BIT_LEDF - 1], wdata_i[`FFR_BIT_INVSTR - 1],
                         wdata_i[`FFR_BIT_I2CERR - 1]} & ~sclr;
      end
      next_st.sflag = srise | (st.sflag & ~sclr);
      // Detail bits clear with string flag
      next_st.gnd = ledsync[0] | (st.gnd & ~sclr[2]);
      next_st.shrt = ledsync[1] | (st.shrt & ~sclr[2]);
      next_st.open = ledsync[2] | (st.open & ~sclr[2]);
      next_st.leds = strsync | (st.leds & ~{`FFR_NUM_STR{sclr[2]}});
      if (wr_i && hit(addr_i, `FFR_OFS_BOOST_MASK)) begin
         next_st.bmask = wdata_i;
      end
      if (wr_i && hit(addr_i, `FFR_OFS_STR_MASK)) begin
         next_st.smask = wdata_i;
      end
      next_st.rdata = `FFR_RESET_VAL;
      if (rd_i) begin
         if (hit(addr_i, `FFR_OFS_BOOST)) begin
            next_st.rdata = boost_word;
         end else if (hit(addr_i, `FFR_OFS_STRING)) begin
            next_st.rdata = str_word;
         end else if (hit(addr_i, `FFR_OFS_BOOST_MASK)) begin
            next_st.rdata = st.bmask;
         end else if (hit(addr_i, `FFR_OFS_STR_MASK)) begin
            next_st.rdata = st.smask;
         end else begin
            next_st.rdata = `FFR_RESET_VAL;
         end
      end
      next_st.irq = |(next_st.bflag & st.bmask[`FFR_NUM_BOOST-1:0]) ||
                    |(next_st.sflag & st.smask[2:0]);
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.bmask <= `FFR_MASK_RESET;
         st.smask <= `FFR_MASK_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign irq_o = st.irq;
endmodule // ffr_top
`default_nettype wire

/* test/ffr_top_asserts.sv */
// Port checker for the fault flag register bank
`timescale 1ns/1ps
`default_nettype none
`include "ffr_params.svh"
module ffr_top_asserts (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Register port
   input wire logic [`FFR_ADDR_W-1:0] addr_i,
   input wire ffr_pkg::ffr_word_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [`FFR_DATA_W-1:0] rdata_o,
   // Faults and interrupt
   input wire logic [`FFR_NUM_BOOST-1:0] boost_fault_i,
   input wire logic i2c_timeout_fault_i,
   input wire logic irq_o
);
   import ffr_pkg::*;
   logic [3:0] quiet;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Cycles since a boost or I2C timeout fault input was high
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) quiet <= 4'hF;
      else if (|boost_fault_i || i2c_timeout_fault_i) quiet <= 4'h0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
   end
   sequence s_clr(int k);
      (!boost_fault_i[k])[*8] ##0 wr_i && addr_i == `FFR_OFS_BOOST && wdata_i[2*k+1]
         && wdata_i[2*k] ##1 rd_i && addr_i == `FFR_OFS_BOOST;
   endsequence
   sequence s_held(int k);
      (boost_fault_i[k] && !wr_i)[*8] ##0 rd_i && addr_i == `FFR_OFS_BOOST;
   endsequence
   property p_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("read data outside read");
   property p_unmap;
      $past(rd_i) && !($past(addr_i) inside {`FFR_OFS_BOOST, `FFR_OFS_STRING, `FFR_OFS_STR_MASK,
         `FFR_OFS_BOOST_MASK, `FFR_OFS_LED_LIVE}) |-> rdata_o == 16'h0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_clr_ovpl; s_clr(0) |=> !rdata_o[1]; endproperty
   a_clr_ovpl: assert property (p_clr_ovpl) else $error("low ovp flag kept");
   property p_clr_ocp; s_clr(2) |=> !rdata_o[5]; endproperty
   a_clr_ocp: assert property (p_clr_ocp) else $error("ocp flag kept");
   property p_clr_current_set_resistor; s_clr(6) |=> !rdata_o[13]; endproperty
   a_clr_current_set_resistor: assert property (p_clr_current_set_resistor) else $error("bit 13 flag kept");
   property p_set_ovpl; s_held(0) |=> rdata_o[1]; endproperty
   a_set_ovpl: assert property (p_set_ovpl) else $error("low ovp flag missing");
   property p_set_ocp; s_held(2) |=> rdata_o[5]; endproperty
   a_set_ocp: assert property (p_set_ocp) else $error("ocp flag missing");
   property p_fall; $fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2); endproperty
   a_fall: assert property (p_fall) else $error("irq fell without write");
   property p_rise; $rose(irq_o) |-> quiet < 4'h8 || $past(wr_i) || $past(wr_i, 2); endproperty
   a_rise: assert property (p_rise) else $error("irq rose without cause");
   c_clear: cover property (s_clr(0));
   c_irq: cover property ($rose(irq_o));
   c_unmap: cover property (rd_i && addr_i == 8'h30);
endmodule // ffr_top_asserts
bind ffr_top ffr_top_asserts u_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .boost_fault_i(boost_fault_i), .i2c_timeout_fault_i(i2c_timeout_fault_i), .irq_o(irq_o));
`default_nettype wire

/* test/ffr_top_tb.sv */
// Self-checking bench for the fault flag register bank
`timescale 1ns/1ps
`default_nettype none
`include "ffr_params.svh"
module ffr_top_tb;
   import ffr_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   ffr_word_t wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic [7:0] bf = 8'h00;
   logic i2c = 1'b0;
   logic irq;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int model = 0;
   int v;
   initial begin
      forever #5 clk = ~clk;
   end
   ffr_top DUT (.ref_clk_i(clk), .arst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .boost_fault_i(bf), .i2c_timeout_fault_i(i2c),
      .invalid_string_fault_i(1'b0), .led_gnd_fault_i(1'b0), .led_short_fault_i(1'b0),
      .led_open_fault_i(1'b0), .led_string_fault_i(4'h0), .irq_o(irq));
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
      n_compared++;
      if ((got & m) !== (exp & m)) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrt(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, exp, m);
      @(posedge clk);
   endtask
   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({15'h0000, irq}, {15'h0000, exp}, 16'h0001);
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      v = $urandom(32'hc428);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(`FFR_OFS_BOOST, 16'h0000, 16'hFFFF);
      rdc(`FFR_OFS_STRING, 16'h0000, 16'hFFFF);
      rdc(8'h30, 16'h0000, 16'hFFFF);
      for (int i = 0; i < 8; i++) begin
         bf[i] <= 1'b1;
         repeat (3) @(posedge clk);
         bf[i] <= 1'b0;
         repeat (8) @(posedge clk);
         model |= 1 << (2 * i + 1);
         rdc(`FFR_OFS_BOOST, 16'(model), 16'hAAAA);
         irq_chk(1'b1);
      end
      for (int i = 0; i < 8; i++) begin
         wrt(`FFR_OFS_BOOST, 16'(1 << (2 * i + 1)));
         @(posedge clk);
         wrt(`FFR_OFS_BOOST, 16'(1 << (2 * i)));
         rdc(`FFR_OFS_BOOST, 16'(model), 16'hAAAA);
         wrt(`FFR_OFS_BOOST, 16'(3 << (2 * i)));
         model &= ~(1 << (2 * i + 1));
         rdc(`FFR_OFS_BOOST, 16'(model), 16'hAAAA);
      end
      irq_chk(1'b0);
      repeat (6) begin
         v = $urandom & 32'hFF;
         bf <= 8'(v);
         repeat (10) @(posedge clk);
         model = 0;
         for (int i = 0; i < 8; i++) begin
            if (v[i]) model |= 1 << (2 * i + 1);
         end
         rdc(`FFR_OFS_BOOST, 16'(model), 16'hAAAA);
         bf <= 7'h00;
         repeat (9) @(posedge clk);
         wrt(`FFR_OFS_BOOST, 16'hFFFF);
         rdc(`FFR_OFS_BOOST, 16'h0000, 16'hAAAA);
      end
      i2c <= 1'b1;
      repeat (3) @(posedge clk);
      i2c <= 1'b0;
      repeat (8) @(posedge clk);
      rdc(`FFR_OFS_STRING, 16'h4000, 16'h4000);
      wrt(`FFR_OFS_STR_MASK, 16'h0000);
      irq_chk(1'b0);
      wrt(`FFR_OFS_STR_MASK, 16'hFFFF);
      irq_chk(1'b1);
      wrt(`FFR_OFS_STRING, 16'h6000);
      irq_chk(1'b0);
      end_of_test();
   end
endmodule // ffr_top_tb
`default_nettype wire
